// file: hw/cbc_pkg.sv
// Package of offsets, field layouts and codes for the clock and bus configuration bytes
`default_nettype none
package cbc_pkg;
   // ************************************************************
   // Register indices; each register's byte address is four times its index
   // ************************************************************
   localparam logic [21:0] CBC_CLOCK_SOURCE_ADDR  = 22'h300002;
   localparam logic [21:0] CBC_WATCHDOG_RATIO_ADDR = 22'h300003;
   localparam logic [21:0] CBC_EXTERNAL_BUS_ADDR  = 22'h300004;
   localparam logic [21:0] CBC_BASE_ADDR          = 22'h300000;

   // ************************************************************
   // Field layouts and implemented-bit masks
   // ************************************************************
   localparam int unsigned CBC_TWO_SPEED_BIT   = 7;
   localparam int unsigned CBC_FAIL_MON_BIT    = 6;
   localparam int unsigned CBC_OSC_LSB         = 0;
   localparam int unsigned CBC_WDT_LSB         = 0;
   localparam int unsigned CBC_WAIT_BIT        = 7;
   localparam int unsigned CBC_BUS_WIDTH_BIT   = 6;
   localparam int unsigned CBC_MEM_MODE_LSB    = 4;
   localparam int unsigned CBC_ADDR_SHIFT_BIT  = 3;
   localparam logic [7:0]  CBC_CLOCK_SOURCE_MASK  = 8'hc7;
   localparam logic [7:0]  CBC_WATCHDOG_RATIO_MASK = 8'h0f;
   localparam logic [7:0]  CBC_WATCHDOG_FIXED_ONES = 8'hf0;
   localparam logic [7:0]  CBC_EXTERNAL_BUS_MASK  = 8'hf8;
   localparam logic [7:0]  CBC_UNPROGRAMMED       = 8'hff;

   // ************************************************************
   // Codes
   // ************************************************************
   localparam logic [1:0] CBC_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] CBC_HSIZE_WORD    = 3'h2;
   localparam logic [3:0] CBC_WDT_RATIO_MAX = 4'hc;
   localparam logic [3:0] CBC_WDT_EXP_W     = 4'h4;

   typedef enum logic [1:0] {
      CBC_OSC_PRIMARY_PINS_EXT_CLK,
      CBC_OSC_PRIMARY_PINS_CRYSTAL,
      CBC_OSC_INTERNAL_CLKOUT,
      CBC_OSC_INTERNAL_PORTS
   } cbc_osc_arrangement_t;
endpackage
`default_nettype wire

// file: hw/cbc_fuse_byte.sv
// One write-once configuration byte with masked unimplemented bits
`default_nettype none
module cbc_fuse_byte (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic [7:0] impl_mask,
   input  wire logic [7:0] fixed_ones,
   input  wire logic       prog_en,
   input  wire logic [7:0] prog_data,
   output logic      [7:0] value,
   output logic            programmed
);
   import cbc_pkg::*;

   logic [7:0] bits_q;
   logic [7:0] bits_d;
   logic       done_q;
   logic       done_d;

   // Fuse contents do not survive reset; every reset reloads the blank state, as at power-on.
   // A synchronous reset stands in for power-on here.
   always_comb begin
      bits_d = bits_q;
      done_d = done_q;
      if (prog_en && !done_q) begin
         bits_d = prog_data & impl_mask;
         done_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bits_q <= CBC_UNPROGRAMMED & impl_mask;
         done_q <= 1'b0;
      end else begin
         bits_q <= bits_d;
         done_q <= done_d;
      end
   end

   assign value      = (bits_q & impl_mask) | fixed_ones;
   assign programmed = done_q;
endmodule
`default_nettype wire

// file: hw/cbc_osc_decode.sv
// Decode of the oscillator choice into primary source and pin functions
`default_nettype none
module cbc_osc_decode (
   input  wire logic [2:0]                  oscillator_choice,
   output cbc_pkg::cbc_osc_arrangement_t    arrangement,
   output logic                             pll_available,
   output logic                             oscillator_pins_primary,
   output logic                             internal_oscillator_primary,
   output logic                             external_clock_input,
   output logic                             fast_crystal_osc,
   output logic                             clock_out_pin,
   output logic                             port_a_pin6,
   output logic                             port_a_pin7
);
   import cbc_pkg::*;

   always_comb begin
      arrangement                 = CBC_OSC_INTERNAL_PORTS;
      oscillator_pins_primary     = 1'b0;
      internal_oscillator_primary = 1'b0;
      external_clock_input        = 1'b0;
      fast_crystal_osc            = 1'b0;
      clock_out_pin               = 1'b0;
      port_a_pin6                 = 1'b0;
      port_a_pin7                 = 1'b0;
      // Odd codes add the software-controlled PLL
      pll_available               = oscillator_choice[0];
      unique case (oscillator_choice[2:1])
         2'h3: begin
            arrangement             = CBC_OSC_PRIMARY_PINS_EXT_CLK;
            oscillator_pins_primary = 1'b1;
            external_clock_input    = 1'b1;
            clock_out_pin           = 1'b1;
         end
         2'h2: begin
            arrangement             = CBC_OSC_PRIMARY_PINS_CRYSTAL;
            oscillator_pins_primary = 1'b1;
            fast_crystal_osc        = 1'b1;
         end
         2'h1: begin
            arrangement                 = CBC_OSC_INTERNAL_CLKOUT;
            internal_oscillator_primary = 1'b1;
            external_clock_input        = 1'b1;
            clock_out_pin               = 1'b1;
            port_a_pin7                 = 1'b1;
         end
         2'h0: begin
            arrangement                 = CBC_OSC_INTERNAL_PORTS;
            internal_oscillator_primary = 1'b1;
            fast_crystal_osc            = 1'b1;
            port_a_pin6                 = 1'b1;
            port_a_pin7                 = 1'b1;
         end
      endcase
   end
endmodule
`default_nettype wire

// file: hw/cbc_config_bank.sv
// Clock and external bus configuration bytes behind an AHB-Lite slave
//
// Notes on behaviour
// - Top clock bit enables two-speed start-up
// - Bit 6 enables fail-safe clock monitor
// - Codes 111/110: pins, external clock, clock-out
// - Codes 101/100: pins, fast crystal oscillator
// - Codes 011/010: internal oscillator, clock-out, pin7 port
// - Codes 001/000: internal oscillator, pins 6/7 ports
// - Clock byte bits 5..3 read zero
// - Bus width bit: 1=16-bit, 0=8-bit
// - Memory bus mode picks address width/disable
// - External bus byte exists on 80-pin only
// - External bus bits 2..0 read zero
`default_nettype none
module cbc_config_bank #(
   parameter bit HAS_EXTERNAL_BUS = 1'b1
) (
   input  wire logic                         sys_clk,
   input  wire logic                         reset,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic      [31:0]                  hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic                              two_speed_startup_en,
   output logic                              clock_fail_monitor_en,
   output logic      [2:0]                   oscillator_choice,
   output cbc_pkg::cbc_osc_arrangement_t     osc_arrangement,
   output logic                              pll_available,
   output logic                              oscillator_pins_primary,
   output logic                              internal_oscillator_primary,
   output logic                              external_clock_input,
   output logic                              fast_crystal_osc,
   output logic                              clock_out_pin,
   output logic                              port_a_pin6,
   output logic                              port_a_pin7,
   output logic      [3:0]                   watchdog_ratio,
   output logic      [15:0]                  watchdog_divide,
   output logic                              bus_wait_en,
   output logic                              bus_width_choice,
   output logic      [1:0]                   memory_bus_mode,
   output logic                              address_shift_en
);
   import cbc_pkg::*;

   // ************************************************************
   // Helpers
   // ************************************************************
   // Each register index owns one aligned word; its byte address is four times the index
   function automatic logic hits(input logic [31:0] a, input logic [21:0] idx);
      hits = (a == {8'h00, idx, 2'h0});
   endfunction

   // ************************************************************
   // Bus address phase capture
   // ************************************************************
   logic        wr_pend_q, wr_pend_d;
   logic [31:0] addr_q, addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic        take;
   logic        word_acc;

   logic [7:0] clk_val, wdt_val, bus_val;
   logic [7:0] ext_mask;
   logic       sel_clk, sel_wdt, sel_bus;
   logic       rsel_clk, rsel_wdt, rsel_bus;

   assign take     = hsel && hready && (htrans == CBC_HTRANS_NONSEQ);
   assign word_acc = (hsize == CBC_HSIZE_WORD);
   // 80-pin parts only; smaller parts leave the whole byte empty
   assign ext_mask = HAS_EXTERNAL_BUS ? CBC_EXTERNAL_BUS_MASK : 8'h00;

   assign sel_clk  = wr_pend_q && hready && hits(addr_q, CBC_CLOCK_SOURCE_ADDR);
   assign sel_wdt  = wr_pend_q && hready && hits(addr_q, CBC_WATCHDOG_RATIO_ADDR);
   assign sel_bus  = wr_pend_q && hready && hits(addr_q, CBC_EXTERNAL_BUS_ADDR);
   assign rsel_clk = hits(haddr, CBC_CLOCK_SOURCE_ADDR);
   assign rsel_wdt = hits(haddr, CBC_WATCHDOG_RATIO_ADDR);
   assign rsel_bus = hits(haddr, CBC_EXTERNAL_BUS_ADDR);

   always_comb begin
      wr_pend_d = 1'b0;
      addr_d    = addr_q;
      rdata_d   = rdata_q;
      if (take) begin
         // Narrow accesses are answered OKAY but never program a byte
         wr_pend_d = hwrite && word_acc;
         addr_d    = haddr;
         rdata_d   = 32'h0;
         // Read data is latched in the address phase; unmapped or narrow reads give zero
         if (!hwrite && word_acc) begin
            if (rsel_clk) begin
               rdata_d = {24'h0, clk_val};
            end else if (rsel_wdt) begin
               rdata_d = {24'h0, wdt_val};
            end else if (rsel_bus) begin
               rdata_d = {24'h0, bus_val};
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 32'h0;
         rdata_q   <= 32'h0;
      end else begin
         wr_pend_q <= wr_pend_d;
         addr_q    <= addr_d;
         rdata_q   <= rdata_d;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   // ************************************************************
   // Configuration bytes
   // ************************************************************
   cbc_fuse_byte u_clock_source (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .impl_mask  (CBC_CLOCK_SOURCE_MASK),
      .fixed_ones (8'h00),
      .prog_en    (sel_clk),
      .prog_data  (hwdata[7:0]),
      .value      (clk_val),
      .programmed ()
   );

   // Upper nibble reads one whatever is written; the programmer is meant to write ones there
   cbc_fuse_byte u_watchdog_ratio (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .impl_mask  (CBC_WATCHDOG_RATIO_MASK),
      .fixed_ones (CBC_WATCHDOG_FIXED_ONES),
      .prog_en    (sel_wdt),
      .prog_data  (hwdata[7:0]),
      .value      (wdt_val),
      .programmed ()
   );

   cbc_fuse_byte u_external_bus (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .impl_mask  (ext_mask),
      .fixed_ones (8'h00),
      .prog_en    (sel_bus),
      .prog_data  (hwdata[7:0]),
      .value      (bus_val),
      .programmed ()
   );

   // ************************************************************
   // Settings to the consumers
   // ************************************************************
   assign two_speed_startup_en  = clk_val[CBC_TWO_SPEED_BIT];
   assign clock_fail_monitor_en = clk_val[CBC_FAIL_MON_BIT];
   assign oscillator_choice     = clk_val[CBC_OSC_LSB +: 3];

   cbc_osc_decode u_osc_decode (
      .oscillator_choice           (oscillator_choice),
      .arrangement                 (osc_arrangement),
      .pll_available               (pll_available),
      .oscillator_pins_primary     (oscillator_pins_primary),
      .internal_oscillator_primary (internal_oscillator_primary),
      .external_clock_input        (external_clock_input),
      .fast_crystal_osc            (fast_crystal_osc),
      .clock_out_pin               (clock_out_pin),
      .port_a_pin6                 (port_a_pin6),
      .port_a_pin7                 (port_a_pin7)
   );

   // Codes above the last listed one saturate at the largest ratio
   always_comb begin
      watchdog_ratio = wdt_val[CBC_WDT_LSB +: 4];
      if (watchdog_ratio > CBC_WDT_RATIO_MAX) begin
         watchdog_divide = 16'h1 << CBC_WDT_RATIO_MAX;
      end else begin
         watchdog_divide = 16'h1 << watchdog_ratio;
      end
   end

   assign bus_wait_en      = bus_val[CBC_WAIT_BIT];
   assign bus_width_choice = bus_val[CBC_BUS_WIDTH_BIT];
   assign memory_bus_mode  = bus_val[CBC_MEM_MODE_LSB +: 2];
   assign address_shift_en = bus_val[CBC_ADDR_SHIFT_BIT];
endmodule
`default_nettype wire

// file: verif/cbc_config_bank_monitor.sv
// Checker of the bus answer and decoded outputs of the configuration bank
`default_nettype none
module cbc_config_bank_monitor (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        two_speed_startup_en,
   input wire logic        clock_fail_monitor_en,
   input wire logic [2:0]  oscillator_choice,
   input wire logic        pll_available,
   input wire logic        oscillator_pins_primary,
   input wire logic        internal_oscillator_primary,
   input wire logic        clock_out_pin,
   input wire logic        port_a_pin6,
   input wire logic        port_a_pin7,
   input wire logic [3:0]  watchdog_ratio,
   input wire logic [15:0] watchdog_divide,
   input wire logic        bus_wait_en,
   input wire logic        bus_width_choice,
   input wire logic [1:0]  memory_bus_mode,
   input wire logic        address_shift_en
);
   timeunit 1ns;
   timeprecision 1ps;
   import cbc_pkg::*;
   localparam logic [31:0] A_CLK = {8'h00, CBC_CLOCK_SOURCE_ADDR, 2'h0};
   localparam logic [31:0] A_WD  = {8'h00, CBC_WATCHDOG_RATIO_ADDR, 2'h0};
   localparam logic [31:0] A_EB  = {8'h00, CBC_EXTERNAL_BUS_ADDR, 2'h0};
   // ************************************************************
   // Data-phase tracking
   // ************************************************************
   logic        tk;
   logic        rd_q, rd_d, wq_q, wq_d, wc_q, wc_d;
   logic [31:0] ad_q, ad_d;
   assign tk = hsel && hready && htrans == CBC_HTRANS_NONSEQ && hsize == CBC_HSIZE_WORD;
   always_comb begin
      rd_d = tk && !hwrite;
      wq_d = tk && hwrite && haddr == A_CLK;
      ad_d = haddr;
      // Sticky once the first clock-byte write has landed
      wc_d = wc_q || (wq_q && hready);
   end
   always_ff @(posedge sys_clk) begin
      rd_q <= reset ? 1'b0 : rd_d;
      wq_q <= reset ? 1'b0 : wq_d;
      wc_q <= reset ? 1'b0 : wc_d;
      ad_q <= ad_d;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ************************************************************
   // Properties
   // ************************************************************
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
   property p_clk_rd;
      rd_q && ad_q == A_CLK |-> hrdata == {24'h0, two_speed_startup_en,
         clock_fail_monitor_en, 3'h0, oscillator_choice};
   endproperty
   a_clk_rd: assert property (p_clk_rd) else $error("clock read wrong");
   property p_wd_rd; rd_q && ad_q == A_WD |-> hrdata == {24'h0, 4'hf, watchdog_ratio}; endproperty
   a_wd_rd: assert property (p_wd_rd) else $error("watchdog byte read wrong");
   property p_eb_rd;
      rd_q && ad_q == A_EB |-> hrdata == {24'h0, bus_wait_en, bus_width_choice,
         memory_bus_mode, address_shift_en, 3'h0};
   endproperty
   a_eb_rd: assert property (p_eb_rd) else $error("bus read wrong");
   property p_div;
      watchdog_divide == ((watchdog_ratio > 4'hc) ? 16'h1000 : (16'h1 << watchdog_ratio));
   endproperty
   a_div: assert property (p_div) else $error("watchdog divide wrong");
   property p_osc_hi;
      oscillator_choice[2] |-> oscillator_pins_primary && !internal_oscillator_primary
         && !port_a_pin6 && !port_a_pin7 && clock_out_pin == oscillator_choice[1];
   endproperty
   a_osc_hi: assert property (p_osc_hi) else $error("pin oscillator decode wrong");
   property p_osc_lo;
      !oscillator_choice[2] |-> internal_oscillator_primary && port_a_pin7
         && port_a_pin6 == !oscillator_choice[1] && pll_available == oscillator_choice[0];
   endproperty
   a_osc_lo: assert property (p_osc_lo) else $error("internal oscillator decode wrong");
   property p_once;
      wc_q |=> $stable({two_speed_startup_en, clock_fail_monitor_en, oscillator_choice});
   endproperty
   a_once: assert property (p_once) else $error("clock byte changed after first write");
   property p_unmap; rd_q && ad_q == 32'h00c00014 |-> hrdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   c_clk_rd: cover property (rd_q && ad_q == A_CLK);
   c_once: cover property (wc_q && tk && hwrite && haddr == A_CLK);
   c_eb_rd: cover property (rd_q && ad_q == A_EB && memory_bus_mode == 2'h2);
endmodule
bind cbc_config_bank cbc_config_bank_monitor u_mon (
   .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .two_speed_startup_en(two_speed_startup_en),
   .clock_fail_monitor_en(clock_fail_monitor_en), .oscillator_choice(oscillator_choice),
   .pll_available(pll_available), .oscillator_pins_primary(oscillator_pins_primary),
   .internal_oscillator_primary(internal_oscillator_primary), .clock_out_pin(clock_out_pin),
   .port_a_pin6(port_a_pin6), .port_a_pin7(port_a_pin7), .watchdog_ratio(watchdog_ratio),
   .watchdog_divide(watchdog_divide), .bus_wait_en(bus_wait_en),
   .bus_width_choice(bus_width_choice), .memory_bus_mode(memory_bus_mode),
   .address_shift_en(address_shift_en));
`default_nettype wire

// file: verif/cbc_config_bank_bench.sv
// Self-checking bench of the configuration bank over AHB-Lite
`default_nettype none
module cbc_config_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cbc_pkg::*;
   logic        sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0, memory_bus_mode;
   logic [2:0]  hsize = 3'h0, oscillator_choice;
   logic [3:0]  watchdog_ratio;
   logic [15:0] watchdog_divide;
   logic        hreadyout, hresp, two_speed_startup_en, clock_fail_monitor_en, pll_available;
   logic        oscillator_pins_primary, internal_oscillator_primary, external_clock_input;
   logic        fast_crystal_osc, clock_out_pin, port_a_pin6, port_a_pin7, bus_wait_en;
   logic        bus_width_choice, address_shift_en;
   cbc_osc_arrangement_t osc_arrangement;
   wire logic   hready;
   logic [31:0] small_hrdata;
   int          mismatches = 0, checks = 0;
   assign hready = hreadyout;
   always #2.5 sys_clk = ~sys_clk;
   cbc_config_bank u_dut (
      .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .two_speed_startup_en(two_speed_startup_en),
      .clock_fail_monitor_en(clock_fail_monitor_en), .oscillator_choice(oscillator_choice),
      .osc_arrangement(osc_arrangement), .pll_available(pll_available),
      .oscillator_pins_primary(oscillator_pins_primary),
      .internal_oscillator_primary(internal_oscillator_primary),
      .external_clock_input(external_clock_input), .fast_crystal_osc(fast_crystal_osc),
      .clock_out_pin(clock_out_pin), .port_a_pin6(port_a_pin6), .port_a_pin7(port_a_pin7),
      .watchdog_ratio(watchdog_ratio), .watchdog_divide(watchdog_divide),
      .bus_wait_en(bus_wait_en), .bus_width_choice(bus_width_choice),
      .memory_bus_mode(memory_bus_mode), .address_shift_en(address_shift_en));
   // Smaller pin-count part on the same bus: its external bus byte must always read zero
   cbc_config_bank #(.HAS_EXTERNAL_BUS(1'b0)) u_small (
      .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(small_hrdata), .hreadyout(), .hresp(), .two_speed_startup_en(),
      .clock_fail_monitor_en(), .oscillator_choice(), .osc_arrangement(),
      .pll_available(), .oscillator_pins_primary(), .internal_oscillator_primary(),
      .external_clock_input(), .fast_crystal_osc(), .clock_out_pin(), .port_a_pin6(),
      .port_a_pin7(), .watchdog_ratio(), .watchdog_divide(), .bus_wait_en(),
      .bus_width_choice(), .memory_bus_mode(), .address_shift_en());
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Called just after a rising edge; holds each phase until hready is seen high
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= CBC_HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= CBC_HSIZE_WORD;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      r = hrdata;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask
   task automatic do_reset;
      reset <= 1'b1;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_blank;
      logic [31:0] r;
      do_reset();
      xfer(1'b1, 32'h00c00014, 32'hffffffff, r);
      rd(32'h00c00014, 32'h0);
      rd(32'h00c00008, 32'hc7);
      rd(32'h00c0000c, 32'hff);
      rd(32'h00c00010, 32'hf8);
      chk(small_hrdata, 32'h0);
      $display("blank test done");
   endtask
   // Each pass resets to blank, programs all three bytes, then tries to reprogram them
   task automatic t_sweep;
      logic [31:0] r;
      logic [2:0]  c;
      for (int i = 0; i < 16; i++) begin
         c = i[2:0];
         do_reset();
         for (int j = 0; j < 2; j++) begin
            xfer(1'b1, 32'h00c00008, {24'hffffff, i[0], i[1], 3'h7, c} ^ {24'h0, {8{j[0]}}}, r);
            xfer(1'b1, 32'h00c0000c, {24'h0, 4'hf, i[3:0] ^ {4{j[0]}}}, r);
            xfer(1'b1, 32'h00c00010, {24'h0, i[3:0], 4'hf} ^ {24'h0, {8{j[0]}}}, r);
            rd(32'h00c00008, {24'h0, i[0], i[1], 3'h0, c});
            rd(32'h00c0000c, {24'h0, 4'hf, i[3:0]});
            rd(32'h00c00010, {24'h0, i[3:0], 4'h8});
            chk(small_hrdata, 32'h0);
            chk(32'({two_speed_startup_en, clock_fail_monitor_en}),
                32'({i[0], i[1]}));
            chk(32'({pll_available, oscillator_pins_primary, internal_oscillator_primary,
                     clock_out_pin, port_a_pin6, port_a_pin7, external_clock_input,
                     fast_crystal_osc}),
                32'({c[0], c[2], !c[2], c[1], c[2:1] == 2'h0, !c[2], c[1],
                     !c[1]}));
            chk(32'(osc_arrangement), 32'(c[2] ? (c[1] ? CBC_OSC_PRIMARY_PINS_EXT_CLK :
                CBC_OSC_PRIMARY_PINS_CRYSTAL) : (c[1] ? CBC_OSC_INTERNAL_CLKOUT :
                CBC_OSC_INTERNAL_PORTS)));
            chk(32'(watchdog_divide), (i > 12) ? 32'h1000 : (32'h1 << i));
            chk(32'({bus_wait_en, bus_width_choice, memory_bus_mode, address_shift_en}),
                32'({i[3:0], 1'b1}));
         end
      end
      $display("sweep test done");
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      finish_test();
   end
   initial begin
      t_blank();
      t_sweep();
      finish_test();
   end
endmodule
`default_nettype wire
